// *** core/ext_mem_bus_keeper.sv ***
// Bus keeper for the multiplexed lines: remembers the last driven value.
// Assumes the pad resolves a weak keeper drive below the strong output drive.
module ext_mem_bus_keeper #(
  parameter int W = 8
) (
  input wire logic i_clk, // System clock.
  input wire logic i_rst, // Synchronous reset, active high.
  input wire logic i_enable, // Keeper switched on.
  input wire logic [W-1:0] i_drive_oe, // Strong drive enables of the lines.
  input wire logic [W-1:0] i_drive_val, // Strong drive values of the lines.
  output logic [W-1:0] o_keep_en, // Keeper drive enables.
  output logic [W-1:0] o_keep_val // Keeper held values.
);
  logic [W-1:0] hold;
  logic [W-1:0] next_hold;

  // Each line follows its strong drive and keeps that value once released.
  for (genvar b = 0; b < W; b++) begin : g_line
    always_comb begin
      next_hold[b] = i_drive_oe[b] ? i_drive_val[b] : hold[b];
      o_keep_en[b] = i_enable & ~i_drive_oe[b];
    end
  end

  // Registers the held values.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hold <= '0;
    end else begin
      hold <= next_hold;
    end
  end

  assign o_keep_val = hold;
endmodule

// *** core/ext_mem_iface.sv ***
// External parallel memory bus with APB control registers and port pin fallback.
// Assumes the core holds a data-space request until it sees the ready pulse.
// Contract
// - Route each access internally or to the bus; strobe the bus only when external.
// - Low address valid when ALE falls; ALE stays low during data transfer.
// - Internal accesses may pulse ALE and address but never the strobes.
// - Disabled, addresses above internal SRAM do not alias into it.
// - Enable bit hands all bus pins to the interface; zero restores port control.
// - Port output bits at one turn on pull-ups of the AD lines.
// - Keeper holds the last driven AD value while the lines float.
// - External space splits into lower and upper sectors with own waits.
// - Trailing ALE pulse only if the next instruction accesses RAM.
// - Limit field bits 6:4 pick the upper sector start address.
// - Limit zero gives one sector using the upper wait bits.
// - Control bits 3:2 select the upper sector wait code.
// - Control bits 1:0 select the lower sector wait code.
// - Codes add zero, one, two strobe cycles, or two plus an address gap.
// - Low address and data share eight lines; high lines are sized apart.
// - Keeper has its own enable, independent of the interface enable.
module ext_mem_iface #(
  parameter int HI_W = 8
) (
  input wire logic I_CLK, // System clock.
  input wire logic I_RST, // Synchronous reset, active high.
  input wire logic I_PSEL, // APB select.
  input wire logic I_PENABLE, // APB access phase.
  input wire logic I_PWRITE, // APB write.
  input wire logic [11:0] I_PADDR, // APB byte address.
  input wire logic [31:0] I_PWDATA, // APB write data.
  output logic [31:0] O_PRDATA, // APB read data.
  output logic O_PREADY, // APB ready.
  output logic O_PSLVERR, // APB error on unmapped address.
  input wire logic I_REQ, // Core data-space request.
  input wire logic I_WE, // Request is a write.
  input wire logic [15:0] I_ADDR, // Request address.
  input wire logic [7:0] I_WDATA, // Request write data.
  input wire logic I_NEXT_RAM, // Next instruction also accesses RAM.
  output logic O_READY, // Request done pulse.
  output logic O_INT_SEL, // Request served by internal SRAM.
  output logic [7:0] O_RDATA, // Read data from the bus.
  input wire logic [7:0] I_AD_IN, // AD pin levels.
  output logic [7:0] O_AD_OUT, // AD pin drive values.
  output logic [7:0] O_AD_OE, // AD pin drive enables.
  output logic [7:0] O_AD_PULLUP, // AD pull-up enables.
  output logic [7:0] O_AD_KEEP_EN, // AD keeper enables.
  output logic [7:0] O_AD_KEEP_VAL, // AD keeper values.
  output logic [HI_W-1:0] O_HI_OUT, // High address pin values.
  output logic [HI_W-1:0] O_HI_OE, // High address pin enables.
  output logic O_ALE, // Address latch strobe.
  output logic O_ALE_OE, // Address latch pin enable.
  output logic O_RD_N, // Read strobe, active low.
  output logic O_RD_N_OE, // Read pin enable.
  output logic O_WR_N, // Write strobe, active low.
  output logic O_WR_N_OE // Write pin enable.
);
  logic [7:0] ctrl_a;
  logic keeper_en;
  logic [ext_mem_pkg::PORT_W-1:0] port_out;
  logic [ext_mem_pkg::PORT_W-1:0] port_dir;
  logic [7:0] next_ctrl_a;
  logic next_keeper_en;
  logic [ext_mem_pkg::PORT_W-1:0] next_port_out;
  logic [ext_mem_pkg::PORT_W-1:0] next_port_dir;
  logic [9:0] reg_idx;
  logic apb_wr;
  logic hit;
  logic enable;
  ext_mem_pkg::bus_state_t state;
  ext_mem_pkg::bus_state_t next_state;
  logic [15:0] addr_q;
  logic [15:0] next_addr_q;
  logic we_q;
  logic next_we_q;
  logic [7:0] wdata_q;
  logic [7:0] next_wdata_q;
  logic next_ram_q;
  logic next_next_ram_q;
  logic [1:0] wait_q;
  logic [1:0] next_wait_q;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [7:0] ad_s1;
  logic [7:0] ad_s2;
  logic [1:0] sector_wait;
  logic is_ext;
  logic bus_ale;
  logic bus_rd_n;
  logic bus_wr_n;
  logic [7:0] bus_ad;
  logic bus_ad_oe;

  assign enable = ctrl_a[ext_mem_pkg::ENABLE_BIT];
  assign reg_idx = I_PADDR[ext_mem_pkg::ADDR_W-1:ext_mem_pkg::IDX_LSB];
  assign apb_wr = I_PSEL & I_PENABLE & I_PWRITE;
  assign is_ext = (I_ADDR >= ext_mem_pkg::EXT_BASE);

  // APB decode, read mux and register next values; zero-wait slave.
  always_comb begin
    next_ctrl_a = ctrl_a;
    next_keeper_en = keeper_en;
    next_port_out = port_out;
    next_port_dir = port_dir;
    hit = 1'b1;
    O_PRDATA = 32'h00000000;
    case (reg_idx)
      ext_mem_pkg::IDX_CTRL_A: begin
        O_PRDATA = {24'h000000, ctrl_a};
        if (apb_wr) begin
          next_ctrl_a = I_PWDATA[7:0];
        end
      end
      ext_mem_pkg::IDX_CTRL_B: begin
        O_PRDATA[ext_mem_pkg::KEEPER_BIT] = keeper_en;
        if (apb_wr) begin
          next_keeper_en = I_PWDATA[ext_mem_pkg::KEEPER_BIT];
        end
      end
      ext_mem_pkg::IDX_PORT_OUT: begin
        O_PRDATA[ext_mem_pkg::PORT_W-1:0] = port_out;
        if (apb_wr) begin
          next_port_out = I_PWDATA[ext_mem_pkg::PORT_W-1:0];
        end
      end
      ext_mem_pkg::IDX_PORT_DIR: begin
        O_PRDATA[ext_mem_pkg::PORT_W-1:0] = port_dir;
        if (apb_wr) begin
          next_port_dir = I_PWDATA[ext_mem_pkg::PORT_W-1:0];
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    O_PREADY = 1'b1;
    O_PSLVERR = I_PSEL & I_PENABLE & ~hit;
  end

  // Registers the control state; everything clears on reset.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ctrl_a <= ext_mem_pkg::CTRL_RESET;
      keeper_en <= 1'b0;
      port_out <= ext_mem_pkg::PORT_RESET;
      port_dir <= ext_mem_pkg::PORT_RESET;
    end else begin
      ctrl_a <= next_ctrl_a;
      keeper_en <= next_keeper_en;
      port_out <= next_port_out;
      port_dir <= next_port_dir;
    end
  end

  ext_mem_sector_decode u_sector (
    .i_addr(I_ADDR),
    .i_limit(ctrl_a[ext_mem_pkg::SRL_HI:ext_mem_pkg::SRL_LO]),
    .i_upper_wait(ctrl_a[ext_mem_pkg::UWAIT_HI:ext_mem_pkg::UWAIT_LO]),
    .i_lower_wait(ctrl_a[ext_mem_pkg::LWAIT_HI:ext_mem_pkg::LWAIT_LO]),
    .o_wait(sector_wait)
  );

  // Bus sequencer: address phase, strobe with waits, read sync, trailing ALE.
  always_comb begin
    next_state = state;
    next_addr_q = addr_q;
    next_we_q = we_q;
    next_wdata_q = wdata_q;
    next_next_ram_q = next_ram_q;
    next_wait_q = wait_q;
    next_cnt = cnt;
    next_rdata = rdata;
    case (state)
      ext_mem_pkg::ST_IDLE: begin
        if (I_REQ) begin
          next_addr_q = I_ADDR;
          next_we_q = I_WE;
          next_wdata_q = I_WDATA;
          next_next_ram_q = I_NEXT_RAM;
          next_wait_q = sector_wait;
          if (!is_ext) begin
            next_state = ext_mem_pkg::ST_INT;
          end else if (enable) begin
            next_state = ext_mem_pkg::ST_ADDR;
          end else begin
            next_state = ext_mem_pkg::ST_NOMAP;
            next_rdata = 8'h00;
          end
        end
      end
      ext_mem_pkg::ST_INT: begin
        next_state = ext_mem_pkg::ST_IDLE;
      end
      ext_mem_pkg::ST_NOMAP: begin
        next_state = ext_mem_pkg::ST_IDLE;
      end
      ext_mem_pkg::ST_ADDR: begin
        next_state = ext_mem_pkg::ST_LATCH;
      end
      ext_mem_pkg::ST_LATCH: begin
        next_state = ext_mem_pkg::ST_STROBE;
        // Code with gap strobes as long as code two.
        next_cnt = (wait_q == ext_mem_pkg::WAIT_TWO_GAP) ? ext_mem_pkg::WAIT_TWO : wait_q;
      end
      ext_mem_pkg::ST_STROBE: begin
        if (cnt == ext_mem_pkg::WAIT_NONE) begin
          next_state = ext_mem_pkg::ST_SYNC;
        end else begin
          next_cnt = cnt - 2'h1;
        end
      end
      ext_mem_pkg::ST_SYNC: begin
        next_state = ext_mem_pkg::ST_TRAIL;
      end
      ext_mem_pkg::ST_TRAIL: begin
        // The synchroniser now holds the level sampled as the strobe rose.
        if (!we_q) begin
          next_rdata = ad_s2;
        end
        if (wait_q == ext_mem_pkg::WAIT_TWO_GAP) begin
          next_state = ext_mem_pkg::ST_GAP;
        end else begin
          next_state = ext_mem_pkg::ST_IDLE;
        end
      end
      ext_mem_pkg::ST_GAP: begin
        next_state = ext_mem_pkg::ST_IDLE;
      end
      default: begin
        next_state = ext_mem_pkg::ST_IDLE;
      end
    endcase
  end

  // Registers the sequencer and the two-stage AD input synchroniser.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state <= ext_mem_pkg::ST_IDLE;
      addr_q <= 16'h0000;
      we_q <= 1'b0;
      wdata_q <= 8'h00;
      next_ram_q <= 1'b0;
      wait_q <= ext_mem_pkg::WAIT_NONE;
      cnt <= ext_mem_pkg::WAIT_NONE;
      rdata <= 8'h00;
      ad_s1 <= 8'h00;
      ad_s2 <= 8'h00;
    end else begin
      state <= next_state;
      addr_q <= next_addr_q;
      we_q <= next_we_q;
      wdata_q <= next_wdata_q;
      next_ram_q <= next_next_ram_q;
      wait_q <= next_wait_q;
      cnt <= next_cnt;
      rdata <= next_rdata;
      ad_s1 <= I_AD_IN;
      ad_s2 <= ad_s1;
    end
  end

  // Bus-side pin values per state; strobes only move for external cycles.
  always_comb begin
    bus_ale = 1'b0;
    bus_rd_n = 1'b1;
    bus_wr_n = 1'b1;
    bus_ad = addr_q[7:0];
    bus_ad_oe = 1'b0;
    case (state)
      ext_mem_pkg::ST_INT, ext_mem_pkg::ST_ADDR: begin
        bus_ale = 1'b1;
        bus_ad_oe = 1'b1;
      end
      ext_mem_pkg::ST_LATCH: begin
        bus_ad_oe = 1'b1;
      end
      ext_mem_pkg::ST_STROBE: begin
        bus_ad = wdata_q;
        bus_ad_oe = we_q;
        bus_rd_n = we_q;
        bus_wr_n = ~we_q;
      end
      ext_mem_pkg::ST_TRAIL: begin
        bus_ale = next_ram_q;
      end
      default: begin
        bus_ale = 1'b0;
      end
    endcase
  end

  // Pin multiplexing between bus use and plain port use.
  always_comb begin
    if (enable) begin
      O_AD_OUT = bus_ad;
      O_AD_OE = {8{bus_ad_oe}};
      O_HI_OUT = addr_q[15:16-HI_W];
      O_HI_OE = '1;
      O_ALE = bus_ale;
      O_RD_N = bus_rd_n;
      O_WR_N = bus_wr_n;
      O_ALE_OE = 1'b1;
      O_RD_N_OE = 1'b1;
      O_WR_N_OE = 1'b1;
    end else begin
      O_AD_OUT = port_out[ext_mem_pkg::PORT_AD_LO+:8];
      O_AD_OE = port_dir[ext_mem_pkg::PORT_AD_LO+:8];
      O_HI_OUT = port_out[ext_mem_pkg::PORT_HI_LO+:HI_W];
      O_HI_OE = port_dir[ext_mem_pkg::PORT_HI_LO+:HI_W];
      O_ALE = port_out[ext_mem_pkg::PORT_ALE];
      O_RD_N = port_out[ext_mem_pkg::PORT_RD];
      O_WR_N = port_out[ext_mem_pkg::PORT_WR];
      O_ALE_OE = port_dir[ext_mem_pkg::PORT_ALE];
      O_RD_N_OE = port_dir[ext_mem_pkg::PORT_RD];
      O_WR_N_OE = port_dir[ext_mem_pkg::PORT_WR];
    end
    // Pull-ups act on lines that are not strongly driven.
    O_AD_PULLUP = port_out[ext_mem_pkg::PORT_AD_LO+:8] & ~O_AD_OE;
    O_READY = (state == ext_mem_pkg::ST_INT) || (state == ext_mem_pkg::ST_NOMAP) ||
              (state == ext_mem_pkg::ST_TRAIL);
    O_INT_SEL = (state == ext_mem_pkg::ST_INT);
  end

  assign O_RDATA = rdata;

  ext_mem_bus_keeper #(
    .W(8)
  ) u_keeper (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_enable(keeper_en),
    .i_drive_oe(O_AD_OE),
    .i_drive_val(O_AD_OUT),
    .o_keep_en(O_AD_KEEP_EN),
    .o_keep_val(O_AD_KEEP_VAL)
  );

  // Checks on the bus waveforms.
  property p_int_no_strobe;
    @(posedge I_CLK) disable iff (I_RST) (enable && O_INT_SEL) |-> (O_RD_N && O_WR_N);
  endproperty
  a_int_no_strobe: assert property (p_int_no_strobe) else $error("Strobe moved on internal access.");
  property p_addr_at_fall;
    @(posedge I_CLK) disable iff (I_RST) (enable && $fell(O_ALE) && state == ext_mem_pkg::ST_LATCH)
      |-> (O_AD_OE == 8'hFF && O_AD_OUT == addr_q[7:0]);
  endproperty
  a_addr_at_fall: assert property (p_addr_at_fall) else $error("Low address not valid as ALE fell.");
  property p_ale_low_strobe;
    @(posedge I_CLK) disable iff (I_RST) (enable && (!O_RD_N || !O_WR_N)) |-> !O_ALE;
  endproperty
  a_ale_low_strobe: assert property (p_ale_low_strobe) else $error("ALE high during strobe.");
  property p_nomap_zero;
    @(posedge I_CLK) disable iff (I_RST) (state == ext_mem_pkg::ST_NOMAP) |-> (O_RDATA == 8'h00 && !O_INT_SEL);
  endproperty
  a_nomap_zero: assert property (p_nomap_zero) else $error("Unmapped access aliased.");
  property p_strobe_two;
    @(posedge I_CLK) disable iff (I_RST) ($fell(O_RD_N) && enable && wait_q[1])
      |-> !O_RD_N [*3] ##1 O_RD_N;
  endproperty
  a_strobe_two: assert property (p_strobe_two) else $error("Two-wait strobe not three cycles.");
  property p_strobe_none;
    @(posedge I_CLK) disable iff (I_RST) ($fell(O_WR_N) && enable && wait_q == ext_mem_pkg::WAIT_NONE)
      |=> O_WR_N;
  endproperty
  a_strobe_none: assert property (p_strobe_none) else $error("No-wait strobe too long.");
  property p_trail_ale;
    @(posedge I_CLK) disable iff (I_RST) (enable && state == ext_mem_pkg::ST_TRAIL) |-> (O_ALE == next_ram_q);
  endproperty
  a_trail_ale: assert property (p_trail_ale) else $error("Trailing ALE mismatch.");
  property p_gap;
    @(posedge I_CLK) disable iff (I_RST) (state == ext_mem_pkg::ST_TRAIL && wait_q == ext_mem_pkg::WAIT_TWO_GAP)
      |=> (state == ext_mem_pkg::ST_GAP) ##1 !O_READY;
  endproperty
  a_gap: assert property (p_gap) else $error("Missing address gap.");
  property p_keeper;
    @(posedge I_CLK) disable iff (I_RST) (keeper_en && $fell(O_AD_OE[0]))
      |-> (O_AD_KEEP_EN[0] && O_AD_KEEP_VAL[0] == $past(O_AD_OUT[0]));
  endproperty
  a_keeper: assert property (p_keeper) else $error("Keeper lost the last value.");
endmodule

// *** core/ext_mem_pkg.sv ***
// Constants, register map and state encoding of the external memory bus.
// Assumes an APB master with 32-bit data and byte addresses of 12 bits.
package ext_mem_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_CTRL_A = 10'h074;
  localparam logic [9:0] IDX_CTRL_B = 10'h075;
  localparam logic [9:0] IDX_PORT_OUT = 10'h076;
  localparam logic [9:0] IDX_PORT_DIR = 10'h077;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  // Field positions in the control registers.
  localparam int ENABLE_BIT = 7;
  localparam int SRL_HI = 6;
  localparam int SRL_LO = 4;
  localparam int UWAIT_HI = 3;
  localparam int UWAIT_LO = 2;
  localparam int LWAIT_HI = 1;
  localparam int LWAIT_LO = 0;
  localparam int KEEPER_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Port register layout: AD lines, high address lines, then ALE, read, write.
  localparam int PORT_W = 19;
  localparam int PORT_AD_LO = 0;
  localparam int PORT_HI_LO = 8;
  localparam int PORT_ALE = 16;
  localparam int PORT_RD = 17;
  localparam int PORT_WR = 18;
  localparam logic [PORT_W-1:0] PORT_RESET = 19'h00000;
  // Address map.
  localparam logic [15:0] EXT_BASE = 16'h2200;
  localparam logic [15:0] SECTOR_STEP = 16'h2000;
  localparam logic [2:0] SRL_FIRST_SPLIT = 3'h2;
  // Wait-state codes.
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_ONE = 2'h1;
  localparam logic [1:0] WAIT_TWO = 2'h2;
  localparam logic [1:0] WAIT_TWO_GAP = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_INT = 4'h1,
    ST_NOMAP = 4'h2,
    ST_ADDR = 4'h3,
    ST_LATCH = 4'h4,
    ST_STROBE = 4'h5,
    ST_SYNC = 4'h6,
    ST_TRAIL = 4'h7,
    ST_GAP = 4'h8
  } bus_state_t;
endpackage

// *** core/ext_mem_sector_decode.sv ***
// Sector decoder: picks the wait-state code that applies to an external address.
// Assumes the address is already known to lie in the external space.
module ext_mem_sector_decode (
  input wire logic [15:0] i_addr, // Access address.
  input wire logic [2:0] i_limit, // Sector limit select.
  input wire logic [1:0] i_upper_wait, // Upper sector wait code.
  input wire logic [1:0] i_lower_wait, // Lower sector wait code.
  output logic [1:0] o_wait // Wait code for this access.
);
  logic [15:0] upper_start;

  // Codes below the first split make the whole space one upper sector.
  always_comb begin
    if (i_limit < ext_mem_pkg::SRL_FIRST_SPLIT) begin
      upper_start = ext_mem_pkg::EXT_BASE;
    end else begin
      upper_start = 16'(ext_mem_pkg::SECTOR_STEP * i_limit);
    end
    o_wait = (i_addr >= upper_start) ? i_upper_wait : i_lower_wait;
  end
endmodule

// *** test/ext_sram_model.sv ***
// Behavioural external SRAM behind a transparent octal address latch.
// Assumes the bench resolves the shared AD wire and feeds it back in.
module ext_sram_model (
  input wire logic i_ale, // Address latch strobe.
  input wire logic i_rd_n, // Read strobe, active low.
  input wire logic i_rd_oe, // Read pin driven.
  input wire logic i_wr_n, // Write strobe, active low.
  input wire logic i_wr_oe, // Write pin driven.
  input wire logic [7:0] i_ad, // Resolved AD wire.
  input wire logic [7:0] i_hi, // High address lines.
  output logic [7:0] o_d, // Read data driven onto AD.
  output logic o_oe // Drives AD while reading.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535];
  logic [7:0] lat;
  logic [7:0] wq;
  // The latch is transparent while the strobe is high and holds when it falls.
  always_latch if (i_ale) lat <= i_ad;
  // Read data only while the active-low read strobe is asserted.
  assign o_oe = i_rd_oe && !i_rd_n;
  assign o_d = mem[{i_hi, lat}];
  // Write data is followed during the strobe and stored when it is released.
  always_latch if (i_wr_oe && !i_wr_n) wq <= i_ad;
  always @(posedge i_wr_n) if (i_wr_oe) mem[{i_hi, lat}] <= wq;
endmodule

// *** test/tb.sv ***
// Self-checking bench of the external memory bus: APB registers, core accesses, pins.
// Assumes an SRAM model on the bus; the bench resolves the AD wire from all drivers.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
  typedef struct {logic [7:0] ctrl; logic [15:0] addr; int w;} row_t;
  logic I_CLK = 0, I_RST = 1, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0;
  logic [11:0] I_PADDR = 12'h000;
  logic [31:0] I_PWDATA = 32'h00000000, O_PRDATA;
  logic O_PREADY, O_PSLVERR, I_REQ = 0, I_WE = 0, I_NEXT_RAM = 0, O_READY, O_INT_SEL;
  logic [15:0] I_ADDR = 16'h0000, cur = 16'h0000;
  logic [7:0] I_WDATA = 8'h00, O_RDATA, I_AD_IN, O_AD_OUT, O_AD_OE, O_AD_PULLUP, O_AD_KEEP_EN, O_AD_KEEP_VAL;
  logic [7:0] O_HI_OUT, O_HI_OE, m_d, last_ad = 8'h00, r8, d8;
  logic O_ALE, O_ALE_OE, O_RD_N, O_RD_N_OE, O_WR_N, O_WR_N_OE, m_oe, ale_q = 0, seen = 0, e1, is1;
  logic [31:0] r32;
  int fails = 0, check_count = 0, rd_cnt = 0, wr_cnt = 0, ale_cnt = 0, s_rd, s_wr, s_ale, w;
  // Each row: control value, access address, expected strobe cycles (0 for an internal target).
  row_t rows [13] = '{'{8'h80, 16'h0100, 0}, '{8'h8C, 16'h2200, 3}, '{8'h9B, 16'h3000, 3},
    '{8'hA1, 16'h3FFF, 2}, '{8'hA1, 16'h4000, 1}, '{8'hB6, 16'h5FFF, 3}, '{8'hB6, 16'h6000, 2},
    '{8'hC4, 16'h7FFF, 1}, '{8'hC4, 16'h8000, 2}, '{8'hD8, 16'hA000, 3}, '{8'hE3, 16'hBFFF, 3},
    '{8'hF2, 16'hE000, 1}, '{8'hF2, 16'hDFFF, 3}};
  ext_mem_iface #(.HI_W(8)) ext_mem_iface_i (.I_CLK, .I_RST, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
    .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .I_REQ, .I_WE, .I_ADDR, .I_WDATA, .I_NEXT_RAM, .O_READY,
    .O_INT_SEL, .O_RDATA, .I_AD_IN, .O_AD_OUT, .O_AD_OE, .O_AD_PULLUP, .O_AD_KEEP_EN, .O_AD_KEEP_VAL,
    .O_HI_OUT, .O_HI_OE, .O_ALE, .O_ALE_OE, .O_RD_N, .O_RD_N_OE, .O_WR_N, .O_WR_N_OE);
  ext_sram_model ext_sram_model_i (.i_ale(O_ALE), .i_rd_n(O_RD_N), .i_rd_oe(O_RD_N_OE), .i_wr_n(O_WR_N),
    .i_wr_oe(O_WR_N_OE), .i_ad(I_AD_IN), .i_hi(O_HI_OUT), .o_d(m_d), .o_oe(m_oe));
  // Clock of 4 ns.
  initial forever #2 I_CLK = ~I_CLK;
  // Wire level: strong drive, then SRAM, keeper, pull-up; a floating line toggles.
  always_comb for (int b = 0; b < 8; b++) I_AD_IN[b] = O_AD_OE[b] ? O_AD_OUT[b] : m_oe ? m_d[b] :
    O_AD_KEEP_EN[b] ? O_AD_KEEP_VAL[b] : O_AD_PULLUP[b] ? 1'b1 : ~last_ad[b];
  // Bus monitor: counts strobe and latch cycles and checks address framing.
  always @(posedge I_CLK) begin
    if (O_RD_N_OE && !O_RD_N) rd_cnt++;
    if (O_WR_N_OE && !O_WR_N) wr_cnt++;
    if (O_ALE_OE && O_ALE) ale_cnt++;
    if (I_REQ && ((O_RD_N_OE && !O_RD_N) || (O_WR_N_OE && !O_WR_N))) begin
      seen = 1;
      `CHK("ale_low", 1'b0, O_ALE)
      `CHK("hi_addr", cur[15:8], O_HI_OUT)
    end
    if (ale_q && !O_ALE && !seen && cur >= 16'h2200 && O_AD_OE === 8'hFF) `CHK("ad_addr", cur[7:0], O_AD_OUT)
    if (!I_REQ) seen = 0;
    ale_q = O_ALE;
    last_ad = I_AD_IN;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n = 0;
    @(posedge I_CLK);
    I_PSEL <= 1;
    I_PENABLE <= 0;
    I_PWRITE <= wr;
    I_PADDR <= {idx, 2'b00};
    I_PWDATA <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1;
    do begin
      @(posedge I_CLK);
      n++;
      if (n > 20) begin fails++; wrap_up(); end
    end while (O_PREADY !== 1'b1);
    r = O_PRDATA;
    e = O_PSLVERR;
    I_PSEL <= 0;
    I_PENABLE <= 0;
  endtask
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic nr,
    output logic [7:0] r, output logic isel);
    int n = 0;
    @(posedge I_CLK);
    I_REQ <= 1;
    I_WE <= wr;
    I_ADDR <= a;
    I_WDATA <= d;
    I_NEXT_RAM <= nr;
    cur = a;
    do begin
      @(posedge I_CLK);
      n++;
      if (n > 30) begin fails++; wrap_up(); end
    end while (O_READY !== 1'b1);
    isel = O_INT_SEL;
    I_REQ <= 0;
    @(posedge I_CLK);
    r = O_RDATA;
  endtask
  initial begin
    repeat (16) @(posedge I_CLK);
    I_RST <= 0;
    for (int i = 0; i < 4; i++) begin
      apb(0, ext_mem_pkg::IDX_CTRL_A + 10'(i), 32'h0, r32, e1);
      `CHK("reg_reset", 32'h00000000, r32)
    end
    apb(0, 10'h000, 32'h0, r32, e1);
    `CHK("unmapped_err", 1'b1, e1)
    `CHK("unmapped_data", 32'h00000000, r32)
    $display("test regs done");
    foreach (rows[i]) begin
      apb(1, ext_mem_pkg::IDX_CTRL_A, {24'h0, rows[i].ctrl}, r32, e1);
      apb(0, ext_mem_pkg::IDX_CTRL_A, 32'h0, r32, e1);
      `CHK("ctrl_a", {24'h0, rows[i].ctrl}, r32)
      w = rows[i].w;
      d8 = rows[i].addr[7:0] ^ rows[i].addr[15:8] ^ 8'h5A;
      s_wr = wr_cnt;
      acc(1, rows[i].addr, d8, 1'b0, r8, is1);
      `CHK("wr_width", w, wr_cnt - s_wr)
      s_rd = rd_cnt;
      s_ale = ale_cnt;
      acc(0, rows[i].addr, 8'h00, 1'(i), r8, is1);
      `CHK("rd_width", w, rd_cnt - s_rd)
      `CHK("int_sel", (w == 0), is1)
      if (w > 0) begin
        `CHK("rd_data", d8, r8)
        `CHK("ale_pulses", 1 + i % 2, ale_cnt - s_ale)
      end
    end
    $display("test sectors done");
    apb(1, ext_mem_pkg::IDX_CTRL_B, 32'hFF, r32, e1);
    apb(0, ext_mem_pkg::IDX_CTRL_B, 32'h0, r32, e1);
    `CHK("ctrl_b", 32'h00000080, r32)
    apb(1, ext_mem_pkg::IDX_CTRL_A, 32'h80, r32, e1);
    acc(1, 16'h2345, 8'h3C, 1'b0, r8, is1);
    `CHK("keep_val", 8'h3C, O_AD_KEEP_VAL)
    apb(1, ext_mem_pkg::IDX_CTRL_A, 32'h00, r32, e1);
    @(posedge I_CLK);
    `CHK("keep_en", 8'hFF, O_AD_KEEP_EN)
    $display("test keeper done");
    s_rd = rd_cnt;
    acc(0, 16'h3000, 8'h00, 1'b0, r8, is1);
    `CHK("nomap_sel", 1'b0, is1)
    `CHK("nomap_data", 8'h00, r8)
    `CHK("nomap_strobe", 0, rd_cnt - s_rd)
    acc(0, 16'h0100, 8'h00, 1'b0, r8, is1);
    `CHK("int_off_sel", 1'b1, is1)
    $display("test disabled done");
    apb(1, ext_mem_pkg::IDX_PORT_DIR, 32'h00020000, r32, e1);
    apb(1, ext_mem_pkg::IDX_PORT_OUT, 32'h000000A5, r32, e1);
    @(posedge I_CLK);
    `CHK("port_rd_oe", 1'b1, O_RD_N_OE)
    `CHK("port_rd", 1'b0, O_RD_N)
    `CHK("pullup", 8'hA5, O_AD_PULLUP)
    apb(1, ext_mem_pkg::IDX_CTRL_A, 32'h80, r32, e1);
    @(posedge I_CLK);
    `CHK("bus_rd", 1'b1, O_RD_N)
    `CHK("bus_hi_oe", 8'hFF, O_HI_OE)
    `CHK("bus_wr_oe", 1'b1, O_WR_N_OE)
    apb(1, ext_mem_pkg::IDX_CTRL_A, 32'h00, r32, e1);
    apb(1, ext_mem_pkg::IDX_PORT_OUT, 32'h0, r32, e1);
    @(posedge I_CLK);
    `CHK("pullup_off", 8'h00, O_AD_PULLUP)
    $display("test pins done");
    // Reset in mid-run must clear the control fields and the keeper enable again.
    apb(1, ext_mem_pkg::IDX_CTRL_A, 32'hFF, r32, e1);
    @(posedge I_CLK);
    I_RST <= 1;
    repeat (2) @(posedge I_CLK);
    I_RST <= 0;
    apb(0, ext_mem_pkg::IDX_CTRL_A, 32'h0, r32, e1);
    `CHK("ctrl_a_rst", 32'h00000000, r32)
    apb(0, ext_mem_pkg::IDX_CTRL_B, 32'h0, r32, e1);
    `CHK("ctrl_b_rst", 32'h00000000, r32)
    $display("test reset done");
    wrap_up();
  end
endmodule
